//--- design/sync2.sv
`timescale 1ns/1ps
module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta <= '0;
            sync_o <= '0;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule

//--- design/typec_source_mode_and_supply_select.sv
`timescale 1ns/1ps
`include "typec_src_params.svh"
module typec_source_mode_and_supply_select
    import typec_src_pkg::*;
#(
    parameter int unsigned HOLD_CYC = `GATE_DIS_HOLD_CYC
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic sink_present_i,
    input wire logic audio_acc_present_i,
    input wire logic debug_acc_present_i,
    input wire logic dangling_cable_i,
    input wire logic vbus_above_uvlo_i,
    input wire logic gate_disable_input_n_i,
    input wire logic thermal_shutdown_i,
    input wire logic [1:0] requested_level_i,
    output logic gate_drive_output_o,
    output logic digital_supply_output_o,
    output logic attach_indicator_o,
    output logic attach_indicator_oe_o,
    output logic supply_select_mid_o,
    output logic supply_select_mid_oe_o,
    output logic supply_select_high_o,
    output logic supply_select_high_oe_o,
    output logic sleep_o,
    output logic hard_reset_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisation.
    logic [8:0] raw_in;
    logic [8:0] sync_in;
    assign raw_in = {requested_level_i, thermal_shutdown_i, gate_disable_input_n_i, vbus_above_uvlo_i,
                     dangling_cable_i, debug_acc_present_i, audio_acc_present_i, sink_present_i};

    sync2 #(.WIDTH(9)) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i(raw_in),
        .sync_o(sync_in)
    );

    logic sink;
    logic acc;
    logic dangling;
    logic vbus_live;
    logic gd_n;
    logic thermal_shutdown;
    level_t req_level;
    assign sink = sync_in[0];
    assign acc = sync_in[1] | sync_in[2];
    assign dangling = sync_in[3];
    assign vbus_live = sync_in[4];
    assign gd_n = sync_in[5];
    assign thermal_shutdown = sync_in[6];
    assign req_level = level_t'(sync_in[8:7]);

    ////////////////////////////////////////////////////////////////////////////
    // Plug status and internal reset.
    logic valid_term;
    logic [3:0] plug_status;
    logic [3:0] last_status;
    logic status_changed;
    logic int_reset;
    logic [2:0] hr_cnt;
    assign valid_term = (sink | acc) & ~dangling;
    assign plug_status = {sink, sync_in[1], sync_in[2], dangling};
    assign status_changed = plug_status != last_status;
    // Thermal trip and an active hard reset both restart the state machine, the settle count and the gate, supply, sleep and enable outputs.
    assign int_reset = reset_i | thermal_shutdown | (hr_cnt != 3'h0);

    ////////////////////////////////////////////////////////////////////////////
    // Mode state machine.
    src_state_t state;
    src_state_t next_state;
    logic vbus_blocked;
    logic next_vbus_blocked;
    logic [31:0] hold_cnt;
    logic hold_expired;
    logic [1:0] settle_cnt;
    logic settle_done;
    assign hold_expired = hold_cnt >= HOLD_CYC - 1;
    // The synchroniser is cleared with reset, so its outputs are stale for two cycles.
    // Deciding in the start state before then would miss a live VBUS.
    assign settle_done = settle_cnt == 2'(`START_SETTLE_CYC);

    always_ff @(posedge clk_i) begin
        if (int_reset) begin
            settle_cnt <= 2'h0;
        end else if (!settle_done) begin
            settle_cnt <= settle_cnt + 2'h1;
        end
    end

    always_comb begin
        next_state = state;
        next_vbus_blocked = vbus_blocked;
        case (state)
            ST_START: begin
                if (settle_done) begin
                    // Power-up check: a live VBUS here means another source is on the wire.
                    next_vbus_blocked = vbus_live;
                    next_state = valid_term ? ST_AWAKE : ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (status_changed) begin
                    next_state = ST_AWAKE;
                end
            end
            ST_AWAKE: begin
                if (!valid_term) begin
                    next_state = ST_SLEEP;
                end else if (sink) begin
                    next_state = ST_ATTACHED;
                end
            end
            ST_ATTACHED: begin
                if (!sink || dangling) begin
                    next_state = valid_term ? ST_AWAKE : ST_SLEEP;
                end
            end
            default: begin
                next_state = ST_START;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (int_reset) begin
            state <= ST_START;
            vbus_blocked <= 1'b0;
            last_status <= 4'h0;
        end else begin
            state <= next_state;
            vbus_blocked <= next_vbus_blocked;
            last_status <= plug_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Gate-disable hold timer and hard reset pulse.
    always_ff @(posedge clk_i) begin
        if (reset_i || thermal_shutdown) begin
            hold_cnt <= 32'h0;
            hr_cnt <= 3'h0;
        end else if (hr_cnt != 3'h0) begin
            hold_cnt <= 32'h0;
            hr_cnt <= hr_cnt - 3'h1;
        end else if (state == ST_ATTACHED && !gd_n) begin
            if (hold_expired) begin
                hold_cnt <= 32'h0;
                hr_cnt <= 3'(`HARD_RESET_CYC);
            end else begin
                hold_cnt <= hold_cnt + 32'h1;
            end
        end else begin
            hold_cnt <= 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs.
    logic attached;
    logic next_gate;
    logic sel_mid;
    logic sel_high;
    // A sink behind a dangling cable is not an attachment, even for the one cycle before leaving.
    assign attached = (state == ST_ATTACHED) & valid_term;
    // Gate-disable low forces the switch off regardless of state.
    assign next_gate = attached & gd_n & ~vbus_blocked;
    assign sel_mid = attached & (req_level == `LEVEL_12V || req_level == `LEVEL_20V);
    assign sel_high = attached & (req_level == `LEVEL_20V);

    always_ff @(posedge clk_i) begin
        if (int_reset) begin
            gate_drive_output_o <= 1'b0;
            digital_supply_output_o <= 1'b0;
            attach_indicator_oe_o <= 1'b0;
            supply_select_mid_oe_o <= 1'b0;
            supply_select_high_oe_o <= 1'b0;
            sleep_o <= 1'b0;
        end else begin
            gate_drive_output_o <= next_gate;
            digital_supply_output_o <= (state == ST_AWAKE || attached) && valid_term;
            attach_indicator_oe_o <= attached;
            supply_select_mid_oe_o <= sel_mid;
            supply_select_high_oe_o <= sel_high;
            sleep_o <= next_state == ST_SLEEP;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            hard_reset_o <= 1'b0;
            attach_indicator_o <= 1'b0;
            supply_select_mid_o <= 1'b0;
            supply_select_high_o <= 1'b0;
        end else begin
            hard_reset_o <= hr_cnt != 3'h0;
            // Open-drain data is always low; only the enables move.
            attach_indicator_o <= 1'b0;
            supply_select_mid_o <= 1'b0;
            supply_select_high_o <= 1'b0;
        end
    end
endmodule

//--- design/typec_src_params.svh
`ifndef TYPEC_SRC_PARAMS_SVH
`define TYPEC_SRC_PARAMS_SVH

// Gate-disable hold time before a hard reset, in milliseconds.
`define GATE_DIS_HOLD_MS 600
// Clock rate in kHz (25 MHz).
`define CLK_KHZ 25000
// Cycles of gate-disable hold: 600 ms at 25 MHz.
`define GATE_DIS_HOLD_CYC (`GATE_DIS_HOLD_MS * `CLK_KHZ)
// Hard reset pulse length in cycles.
`define HARD_RESET_CYC 4
// Cycles spent in the start state before the synchronised inputs are trusted.
`define START_SETTLE_CYC 2
// Requested level codes.
`define LEVEL_5V 2'h0
`define LEVEL_12V 2'h1
`define LEVEL_20V 2'h2

`endif

//--- design/typec_src_pkg.sv
package typec_src_pkg;
    typedef enum logic [3:0] {
        ST_START = 4'b0001,
        ST_SLEEP = 4'b0010,
        ST_AWAKE = 4'b0100,
        ST_ATTACHED = 4'b1000
    } src_state_t;
    typedef logic [1:0] level_t;
endpackage

//--- tb/typec_far_side_model.sv
`timescale 1ns/1ps
// Sink plus external supply; select pins have pull-ups, so a released pin reads high.
module typec_far_side_model (
    input wire logic attach_i,
    input wire logic [1:0] level_i,
    input wire logic drop_i,
    input wire logic mid_oe_i,
    input wire logic high_oe_i,
    output logic sink_o,
    output logic [1:0] req_o,
    output logic gd_n_o,
    output logic [1:0] supply_o
);
assign sink_o = attach_i;
assign req_o = level_i;
assign gd_n_o = !drop_i;
assign supply_o = (!high_oe_i && mid_oe_i) ? 2'h1 : ((high_oe_i) ? 2'h2 : 2'h0);
endmodule

//--- tb/typec_source_mode_and_supply_select_tb_top.sv
`timescale 1ns/1ps
module typec_source_mode_and_supply_select_tb_top;
import typec_src_pkg::*;
logic clk_i = 0, reset_i = 1, aud = 0, dbg = 0, dng = 0, vb = 0, ot = 0, att = 0, drop = 0;
level_t lvl = 0, req, sup;
logic sink, gdn, gate, digital_supply_output, attach_indicator, mid, hi, slp, hrst, seen;
int fail_count = 0, n_compared = 0, cyc = 0;
typec_source_mode_and_supply_select #(.HOLD_CYC(20)) dut (.clk_i(clk_i), .reset_i(reset_i),
    .sink_present_i(sink), .audio_acc_present_i(aud), .debug_acc_present_i(dbg), .dangling_cable_i(dng),
    .vbus_above_uvlo_i(vb), .gate_disable_input_n_i(gdn), .thermal_shutdown_i(ot), .requested_level_i(req),
    .gate_drive_output_o(gate), .digital_supply_output_o(digital_supply_output), .attach_indicator_o(),
    .attach_indicator_oe_o(attach_indicator), .supply_select_mid_o(), .supply_select_mid_oe_o(mid),
    .supply_select_high_o(), .supply_select_high_oe_o(hi), .sleep_o(slp), .hard_reset_o(hrst));
typec_far_side_model far (.attach_i(att), .level_i(lvl), .drop_i(drop), .mid_oe_i(mid), .high_oe_i(hi),
    .sink_o(sink), .req_o(req), .gd_n_o(gdn), .supply_o(sup));
initial forever #20 clk_i = ~clk_i;
always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
        fail_count++;
        results();
    end
end
task step(int n); repeat (n) @(posedge clk_i); #2; endtask
task chk(logic got, logic exp);
    n_compared++;
    if (got !== exp) begin fail_count++; $display("CHECK FAILED %0t flag %b not %b", $time, got, exp); end
endtask
task chk2(level_t got, level_t exp);
    n_compared++;
    if (got !== exp) begin fail_count++; $display("CHECK FAILED %0t level %h not %h", $time, got, exp); end
endtask
task rst(logic v); vb = v; reset_i = 1; step(10); reset_i = 0; endtask
task t_sleep;
    rst(0); step(8); chk(slp, 1);
    dng = 1; step(8); chk(slp, 1);
    dng = 0; att = 1; step(8); chk(slp, 0);
    chk(digital_supply_output, 1);
    chk(attach_indicator, 1);
    $display("sleep test done");
endtask
task t_levels;
    for (int i = 2; i >= 0; i--) begin lvl = level_t'(i); step(8); chk2(sup, level_t'(i)); end
    $display("level test done");
endtask
task t_acc;
    lvl = 2'h2; step(8); att = 0; aud = 1; step(8); chk(digital_supply_output, 1);
    chk(attach_indicator, 0);
    chk2(sup, 2'h0);
    aud = 0; dbg = 1; step(8); chk(digital_supply_output, 1);
    dbg = 0; step(8); chk(digital_supply_output, 0);
    $display("accessory test done");
endtask
task t_gd;
    att = 1; lvl = 0; step(8); chk(gate, 1); drop = 1; step(5); chk(gate, 0);
    seen = 0;
    repeat (40) begin step(1); seen |= hrst; end
    chk(seen, 1);
    drop = 0; $display("gate disable test done");
endtask
task t_vbus_thermal_shutdown;
    att = 0; rst(1); att = 1; step(10); chk(gate, 0);
    rst(0); step(10); ot = 1; step(6); chk(digital_supply_output, 0);
    chk(gate, 0);
    ot = 0; $display("vbus and thermal test done");
endtask
task results;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
endtask
initial begin
    t_sleep(); t_levels(); t_acc(); t_gd(); t_vbus_thermal_shutdown();
    results();
end
endmodule
bind typec_source_mode_and_supply_select typec_src_checker chk_i (.clk_i, .reset_i, .gate_disable_input_n_i,
    .thermal_shutdown_i, .requested_level_i, .gate_drive_output_o, .digital_supply_output_o, .attach_indicator_oe_o,
    .supply_select_mid_o, .supply_select_mid_oe_o, .supply_select_high_o, .supply_select_high_oe_o, .sleep_o,
    .hard_reset_o);

//--- tb/typec_src_properties.sv
`timescale 1ns/1ps
module typec_src_checker (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic gate_disable_input_n_i,
    input wire logic thermal_shutdown_i,
    input wire logic [1:0] requested_level_i,
    input wire logic gate_drive_output_o,
    input wire logic digital_supply_output_o,
    input wire logic attach_indicator_oe_o,
    input wire logic supply_select_mid_o,
    input wire logic supply_select_mid_oe_o,
    input wire logic supply_select_high_o,
    input wire logic supply_select_high_oe_o,
    input wire logic sleep_o,
    input wire logic hard_reset_o
);
default clocking cb @(posedge clk_i); endclocking
default disable iff (reset_i);
sel_drain_a: assert property (!supply_select_mid_o && !supply_select_high_o) else $error("select driven high");
high_mid_a: assert property (supply_select_high_oe_o |-> supply_select_mid_oe_o) else $error("high without mid");
sel_idle_a: assert property (!attach_indicator_oe_o |-> !supply_select_mid_oe_o) else $error("select unattached");
supply_att_a: assert property (attach_indicator_oe_o |-> digital_supply_output_o) else $error("supply off");
sleep_sup_a: assert property (sleep_o |-> !digital_supply_output_o) else $error("supply in sleep");
gate_off_a: assert property (!gate_disable_input_n_i [*5] |-> !gate_drive_output_o) else $error("gate on");
trip_clr_a: assert property (thermal_shutdown_i [*5] |-> !digital_supply_output_o) else $error("not reset");
mid_sel_a: assert property ((attach_indicator_oe_o && requested_level_i == 2'h1) [*6]
    |-> supply_select_mid_oe_o && !supply_select_high_oe_o) else $error("mid select wrong");
top_sel_a: assert property ((attach_indicator_oe_o && requested_level_i == 2'h2) [*6]
    |-> supply_select_high_oe_o) else $error("high select wrong");
hard_len_a: assert property ($rose(hard_reset_o) |-> hard_reset_o [*4] ##1 !hard_reset_o) else $error("pulse");
c_mid: cover property (supply_select_mid_oe_o && !supply_select_high_oe_o);
c_high: cover property (supply_select_high_oe_o);
c_hard: cover property ($rose(hard_reset_o));
endmodule
